// ### irq_ctrl_defines.vh
// constants for the two level interrupt controller
`ifndef IRQ_CTRL_DEFINES_VH
`define IRQ_CTRL_DEFINES_VH

// ****************************************************************
// sizes
// ****************************************************************
`define NUM_SRC 14
`define SRC_W 4
`define VEC_W 16

// ****************************************************************
// register offsets on the plain port
// ****************************************************************
`define OFF_IRQ_ENABLE 8'h00
`define OFF_EXT_ENABLE_1 8'h01
`define OFF_EXT_ENABLE_2 8'h02
`define OFF_IRQ_PRIORITY 8'h03
`define OFF_EXT_PRIORITY_1 8'h04
`define OFF_EXT_PRIORITY_2 8'h05
`define OFF_PENDING_LO 8'h06
`define OFF_PENDING_HI 8'h07
`define OFF_STATUS 8'h08

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define GLOBAL_EN_BIT 7
`define REG_RESET 8'h00

// ****************************************************************
// vector table: base plus eight bytes per slot
// ****************************************************************
`define VEC_BASE 16'h0003
`define VEC_STEP 16'h0008

// ****************************************************************
// timing in system clock cycles
// ****************************************************************
`define DETECT_CYCLES 1
`define CALL_CYCLES 5

`endif

// ### irq_arbiter.v
// fixed order arbiter: lowest index among the request bits wins
`timescale 1ns/1ps
module irq_arbiter #(
  parameter N = 14,
  parameter W = 4
) (
  // requests
  input wire [N-1:0] req_i,
  // result
  output reg any_o,
  output reg [W-1:0] idx_o
);
  integer i;
  always @* begin
    any_o = 1'b0;
    idx_o = {W{1'b0}};
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (req_i[i]) begin
        any_o = 1'b1;
        idx_o = i[W-1:0];
      end
    end
  end
endmodule // irq_arbiter

// ### two_level_interrupt_controller.v
// two level interrupt controller with pending flags, enables and vectoring
//
// How it works
// (RQ1) fourteen sources, each with a low or high priority level
// (RQ2) a source event sets that source's pending flag
// (RQ3) pending flags set regardless of the source enable bit
// (RQ4) enabled pending source requests; core long-calls its vector after instruction
// (RQ5) return instruction resumes the interrupted program flow
// (RQ6) pending flag of a disabled source gives no request
// (RQ7) per-source enables act only while global enable bit 7 is one
// (RQ8) global enable zero blocks every source
// (RQ9) enable cleared during post: single-cycle next may still vector
// (RQ10) software follows an enable clear with a two-byte instruction
// (RQ11) some flags cleared by hardware on vectoring; rest by software
// (RQ12) flag still set after return re-requests after one instruction
// (RQ13) software writing one to a pending flag acts as an event
// (RQ14) high preempts low; nothing preempts a high routine
// (RQ15) per-source priority bit; reset leaves all low priority
// (RQ16) higher level first, then fixed source order
// (RQ17) requests sampled and priority decoded every clock
// (RQ18) fastest response six cycles: one detect plus five call
// (RQ19) equal or higher level in service holds new request back
// (RQ20) in-service markers set on vectoring, newest released on return
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "irq_ctrl_defines.vh"
module two_level_interrupt_controller (
  // clock and reset
  input wire core_clk_i,
  input wire reset_i,
  // register port
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // source events, one cycle pulses; pins pass a synchroniser first
  input wire [13:0] src_event_i,
  input wire [13:0] src_pin_event_i,
  input wire [13:0] hw_clear_mask_i,
  // core handshake
  input wire instr_done_i,
  input wire next_multi_cycle_i,
  input wire return_from_irq_instr_done_i,
  input wire call_ack_i,
  output reg irq_req_o,
  output reg [15:0] irq_vector_o,
  output reg [3:0] irq_src_o,
  output reg call_active_o,
  output reg [1:0] in_service_o
);

  // ****************************************************************
  // register state
  // ****************************************************************
  reg [7:0] irq_enable_reg_q;
  reg [7:0] ext_irq_enable_reg_1_q;
  reg [7:0] ext_irq_enable_reg_2_q;
  reg [7:0] irq_priority_reg_q;
  reg [7:0] ext_irq_priority_reg_1_q;
  reg [7:0] ext_irq_priority_reg_2_q;
  reg [13:0] pending_q; // [RQ1]
  reg [13:0] pending_d;
  reg [13:0] pin_s1_q;
  reg [13:0] pin_s2_q;
  reg [13:0] pin_s3_q;
  reg [1:0] in_service_q;
  reg [13:0] old_enable_q;

  // ****************************************************************
  // sequencing
  // ****************************************************************
  localparam S_IDLE = 2'd0;
  localparam S_CALL = 2'd1;
  localparam S_HOLD = 2'd2;
  reg [1:0] state_q;
  reg [2:0] call_cnt_q;
  reg [3:0] sel_src_q;
  reg sel_high_q;
  reg hold_one_q;
  reg prev_en_q;

  wire global_irq_enable;
  wire [13:0] src_enable;
  wire [13:0] src_high;
  wire [13:0] pin_rise;
  wire [13:0] active;
  wire [13:0] req_high;
  wire [13:0] req_low;
  wire hi_any;
  wire lo_any;
  wire [3:0] hi_idx;
  wire [3:0] lo_idx;
  wire win_any;
  wire [3:0] win_idx;
  wire win_high;
  wire may_take;
  wire wr_pend_lo;
  wire wr_pend_hi;
  wire [13:0] eff_enable;
  wire eff_global;
  wire wr_enable_word;
  wire call_go;
  wire hw_clear_now;

  assign global_irq_enable = irq_enable_reg_q[`GLOBAL_EN_BIT];
  assign src_enable = {ext_irq_enable_reg_2_q[6:0],
                       irq_enable_reg_q[6:0]};
  assign src_high = {ext_irq_priority_reg_2_q[6:0],
                     irq_priority_reg_q[6:0]}; // [RQ15]
  assign pin_rise = pin_s2_q & ~pin_s3_q;

  // after an enable write made while global enable is one the old enables hold until the next instruction
  // ends, as the core pipeline commits the clear late
  assign eff_enable = src_enable | (old_enable_q & {14{prev_en_q}}); // [RQ9]
  assign eff_global = global_irq_enable | prev_en_q; // [RQ7] [RQ8]
  assign active = pending_q & eff_enable & {14{eff_global}}; // [RQ6] [RQ7]
  assign req_high = active & src_high;
  assign req_low = active & ~src_high;

  // ****************************************************************
  // arbitration, recomputed every cycle
  // ****************************************************************
  irq_arbiter #(.N(`NUM_SRC), .W(`SRC_W)) u_arb_high (
    .req_i(req_high),
    .any_o(hi_any),
    .idx_o(hi_idx)
  ); // [RQ16] [RQ17]
  irq_arbiter #(.N(`NUM_SRC), .W(`SRC_W)) u_arb_low (
    .req_i(req_low),
    .any_o(lo_any),
    .idx_o(lo_idx)
  ); // [RQ16] [RQ17]

  assign win_any = hi_any | lo_any;
  assign win_high = hi_any; // [RQ16]
  assign win_idx = hi_any ? hi_idx : lo_idx;

  // high level in service blocks all; low blocks low only
  assign may_take = win_any && !in_service_q[1] &&
                    !(in_service_q[0] && !win_high); // [RQ14] [RQ19]

  assign wr_pend_lo = reg_wr_i && (reg_addr_i == `OFF_PENDING_LO);
  assign wr_pend_hi = reg_wr_i && (reg_addr_i == `OFF_PENDING_HI);

  // writes that may clear a source enable or the global enable
  assign wr_enable_word = reg_wr_i && (reg_addr_i == `OFF_IRQ_ENABLE ||
                                       reg_addr_i == `OFF_EXT_ENABLE_2);

  // the call needs a request raised on an earlier edge: one detect cycle
  assign call_go = irq_req_o && instr_done_i &&
                   !(prev_en_q && next_multi_cycle_i); // [RQ18] [RQ9]

  // the core acknowledges in the first call cycle
  assign hw_clear_now = (state_q == S_CALL) && call_ack_i &&
                        hw_clear_mask_i[sel_src_q]; // [RQ11]

  // ****************************************************************
  // pin synchroniser
  // ****************************************************************
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_s1_q <= 14'h0000;
      pin_s2_q <= 14'h0000;
      pin_s3_q <= 14'h0000;
    end else begin
      pin_s1_q <= src_pin_event_i;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // ****************************************************************
  // pending flags: events win over any clear
  // ****************************************************************
  always @* begin
    pending_d = pending_q;
    if (wr_pend_lo) begin
      pending_d[7:0] = reg_wdata_i; // [RQ13] [RQ11]
    end
    if (wr_pend_hi) begin
      pending_d[13:8] = reg_wdata_i[5:0]; // [RQ13] [RQ11]
    end
    // a new event in the acknowledge cycle still wins below
    if (hw_clear_now) begin
      pending_d[sel_src_q] = 1'b0; // [RQ11]
    end
    pending_d = pending_d | src_event_i | pin_rise; // [RQ2] [RQ3]
  end

  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pending_q <= 14'h0000;
    end else begin
      pending_q <= pending_d;
    end
  end

  // ****************************************************************
  // enable and priority registers
  // ****************************************************************
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_enable_reg_q <= `REG_RESET;
      ext_irq_enable_reg_1_q <= `REG_RESET;
      ext_irq_enable_reg_2_q <= `REG_RESET;
      irq_priority_reg_q <= `REG_RESET; // [RQ15]
      ext_irq_priority_reg_1_q <= `REG_RESET;
      ext_irq_priority_reg_2_q <= `REG_RESET;
    end else begin
      if (reg_wr_i) begin
        case (reg_addr_i)
          `OFF_IRQ_ENABLE: irq_enable_reg_q <= reg_wdata_i;
          `OFF_EXT_ENABLE_1: ext_irq_enable_reg_1_q <= reg_wdata_i;
          `OFF_EXT_ENABLE_2: ext_irq_enable_reg_2_q <= reg_wdata_i;
          `OFF_IRQ_PRIORITY: irq_priority_reg_q <= reg_wdata_i;
          `OFF_EXT_PRIORITY_1: ext_irq_priority_reg_1_q <= reg_wdata_i;
          `OFF_EXT_PRIORITY_2: ext_irq_priority_reg_2_q <= reg_wdata_i;
          default: begin
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // enable grace after a clearing write
  // ****************************************************************
  // the grace ends with the next instruction; a multi-cycle one refuses it
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      prev_en_q <= 1'b0;
      old_enable_q <= 14'h0000;
    end else if (wr_enable_word && global_irq_enable) begin
      prev_en_q <= 1'b1; // [RQ9]
      old_enable_q <= src_enable;
    end else if (instr_done_i) begin
      prev_en_q <= 1'b0; // [RQ9]
    end
  end

  // ****************************************************************
  // read port, data one cycle after the strobe
  // ****************************************************************
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `OFF_IRQ_ENABLE: reg_rdata_o <= irq_enable_reg_q;
        `OFF_EXT_ENABLE_1: reg_rdata_o <= ext_irq_enable_reg_1_q;
        `OFF_EXT_ENABLE_2: reg_rdata_o <= ext_irq_enable_reg_2_q;
        `OFF_IRQ_PRIORITY: reg_rdata_o <= irq_priority_reg_q;
        `OFF_EXT_PRIORITY_1: reg_rdata_o <= ext_irq_priority_reg_1_q;
        `OFF_EXT_PRIORITY_2: reg_rdata_o <= ext_irq_priority_reg_2_q;
        `OFF_PENDING_LO: reg_rdata_o <= pending_q[7:0];
        `OFF_PENDING_HI: reg_rdata_o <= {2'b00, pending_q[13:8]};
        `OFF_STATUS: reg_rdata_o <= {3'b000, sel_src_q, in_service_q[1]};
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // ****************************************************************
  // request, long call and return sequencing
  // ****************************************************************
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= S_IDLE;
      call_cnt_q <= 3'd0;
      sel_src_q <= 4'd0;
      sel_high_q <= 1'b0;
      hold_one_q <= 1'b0;
      irq_req_o <= 1'b0;
      irq_vector_o <= 16'h0000;
      irq_src_o <= 4'd0;
      call_active_o <= 1'b0;
      in_service_q <= 2'b00;
      in_service_o <= 2'b00;
    end else begin
      in_service_o <= in_service_q;
      case (state_q)
        S_IDLE: begin
          if (return_from_irq_instr_done_i && (in_service_q != 2'b00)) begin
            // newest level goes first: high sits above low
            if (in_service_q[1]) begin
              in_service_q[1] <= 1'b0; // [RQ20] [RQ5]
            end else begin
              in_service_q[0] <= 1'b0; // [RQ20] [RQ5]
            end
            hold_one_q <= 1'b1; // [RQ12] [RQ19]
            irq_req_o <= 1'b0;
          end else if (hold_one_q) begin
            // one more instruction must finish after a return
            if (instr_done_i) begin
              hold_one_q <= 1'b0; // [RQ12]
            end
            irq_req_o <= 1'b0;
          end else if (may_take) begin
            // detection cycle: latch the winner, raise the request
            irq_req_o <= 1'b1; // [RQ4] [RQ18]
            sel_src_q <= win_idx;
            sel_high_q <= win_high;
            irq_src_o <= win_idx;
            irq_vector_o <= `VEC_BASE + ({12'h000, win_idx} * `VEC_STEP);
            if (call_go) begin
              irq_req_o <= 1'b0;
              state_q <= S_CALL; // [RQ4] [RQ9]
              call_active_o <= 1'b1;
              call_cnt_q <= 3'd`CALL_CYCLES - 3'd1;
            end
          end else begin
            irq_req_o <= 1'b0;
          end
        end
        S_CALL: begin
          if (call_cnt_q == 3'd0) begin
            call_active_o <= 1'b0;
            state_q <= S_HOLD;
            // the level marker goes up as the last call cycle ends
            if (sel_high_q) begin
              in_service_q[1] <= 1'b1; // [RQ20] [RQ14]
            end else begin
              in_service_q[0] <= 1'b1; // [RQ20]
            end
          end else begin
            call_cnt_q <= call_cnt_q - 3'd1; // [RQ18]
          end
        end
        S_HOLD: begin
          state_q <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule // two_level_interrupt_controller

// ### irq_ctrl_props.sv
// checker for the two level interrupt controller ports
`timescale 1ns/1ps
module irq_ctrl_props (
  // clock and reset
  input wire core_clk_i,
  input wire reset_i,
  // observed inputs
  input wire reg_rd_i,
  input wire instr_done_i,
  input wire return_from_irq_instr_done_i,
  // observed outputs
  input wire [7:0] reg_rdata_o,
  input wire irq_req_o,
  input wire [15:0] irq_vector_o,
  input wire [3:0] irq_src_o,
  input wire call_active_o,
  input wire [1:0] in_service_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // ****************************************************************
  // sequences and properties
  // ****************************************************************
  sequence s_call;
    call_active_o [*5] ##1 !call_active_o;
  endsequence
  sequence s_hold;
    !$rose(call_active_o);
  endsequence
  property p_rd_idle;
    !$past(reg_rd_i) |-> reg_rdata_o == 8'h00;
  endproperty
  property p_vec;
    irq_req_o |-> irq_vector_o == 16'h0003 + {9'h000, irq_src_o, 3'h0};
  endproperty
  property p_call_len;
    $rose(call_active_o) |-> s_call;
  endproperty
  property p_call_cause;
    $rose(call_active_o) |-> $past(irq_req_o) && $past(instr_done_i);
  endproperty
  property p_mark;
    $fell(call_active_o) |-> ##[0:1] (in_service_o != 2'b00);
  endproperty
  property p_high_block;
    in_service_o[1] |-> !$rose(call_active_o);
  endproperty
  property p_return_from_irq_instr_wait;
    return_from_irq_instr_done_i |=> s_hold;
  endproperty
  property p_req_quiet;
    call_active_o |-> !irq_req_o;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  a_vec: assert property (p_vec) else $error("vector mismatch");
  a_call_len: assert property (p_call_len) else $error("call length");
  a_call_cause: assert property (p_call_cause) else $error("bad call");
  a_mark: assert property (p_mark) else $error("level not marked");
  a_high_block: assert property (p_high_block) else $error("preempt");
  a_return_from_irq_instr_wait: assert property (p_return_from_irq_instr_wait) else $error("early call");
  a_req_quiet: assert property (p_req_quiet) else $error("req in call");
endmodule // irq_ctrl_props

bind two_level_interrupt_controller irq_ctrl_props i_irq_ctrl_props (
  .core_clk_i, .reset_i, .reg_rd_i, .instr_done_i, .return_from_irq_instr_done_i,
  .reg_rdata_o, .irq_req_o, .irq_vector_o, .irq_src_o, .call_active_o,
  .in_service_o);

// ### core_model.sv
// processor core stand-in driving the instruction handshake
`timescale 1ns/1ps
module core_model (
  // clock and reset
  input wire core_clk_i,
  input wire reset_i,
  // from controller and bench
  input wire call_active_i,
  input wire slow_i,
  input wire multi_i,
  input wire return_from_irq_instr_cmd_i,
  // to controller
  output logic instr_done_o,
  output logic return_from_irq_instr_done_o,
  output logic call_ack_o,
  output logic next_multi_cycle_o
);
  logic [1:0] cnt_q;
  logic act_q;
  // slow pacing stretches instructions to four cycles
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q <= 2'h0;
      act_q <= 1'b0;
      return_from_irq_instr_done_o <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == 2'h0) ? (slow_i ? 2'h3 : 2'h1) : cnt_q - 2'h1;
      act_q <= call_active_i;
      return_from_irq_instr_done_o <= return_from_irq_instr_cmd_i;
    end
  end
  // no instruction ends during a call or in the return cycle
  assign instr_done_o = (cnt_q == 2'h0) && !call_active_i && !return_from_irq_instr_done_o;
  assign call_ack_o = call_active_i && !act_q;
  // the bench marks a two-byte instruction after an enable clear
  assign next_multi_cycle_o = multi_i;
endmodule // core_model

// ### testbench.sv
// self-checking bench for the two level interrupt controller
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, slow = 1'b0;
  logic return_from_irq_instr_cmd = 1'b0, multi_s = 1'b0;
  logic [7:0] addr = 8'h00, wd = 8'h00;
  logic [13:0] ev_s = 14'h0000, pin = 14'h0000, hw = 14'h0000;
  wire [7:0] rdata;
  wire req, call, done, multi, return_from_irq_instr, ack;
  wire [15:0] vec;
  wire [3:0] src;
  wire [1:0] ins;
  int n_mismatch = 0, checks_done = 0, cycles = 0;
  initial forever #12.5 clk = ~clk;
  two_level_interrupt_controller i_two_level_interrupt_controller (
    .core_clk_i(clk), .reset_i(rst), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
    .src_event_i(ev_s), .src_pin_event_i(pin), .hw_clear_mask_i(hw),
    .instr_done_i(done), .next_multi_cycle_i(multi), .return_from_irq_instr_done_i(return_from_irq_instr),
    .call_ack_i(ack), .irq_req_o(req), .irq_vector_o(vec), .irq_src_o(src),
    .call_active_o(call), .in_service_o(ins));
  core_model i_core_model (.core_clk_i(clk), .reset_i(rst),
    .call_active_i(call), .slow_i(slow), .multi_i(multi_s),
    .return_from_irq_instr_cmd_i(return_from_irq_instr_cmd), .instr_done_o(done), .return_from_irq_instr_done_o(return_from_irq_instr),
    .call_ack_o(ack), .next_multi_cycle_o(multi));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task stop_test;
    if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wd <= d; wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a; rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, e});
  endtask
  task ev(input logic [13:0] m);
    @(posedge clk);
    ev_s <= m;
    @(posedge clk);
    ev_s <= 14'h0000;
  endtask
  task wait_call(input logic [3:0] s);
    int i;
    i = 0;
    while (call !== 1'b1 && i < 80) begin
      tick(1);
      i++;
    end
    chk({15'h0000, call}, 16'h0001);
    chk({12'h000, src}, {12'h000, s});
    chk(vec, 16'h0003 + {12'h000, s} * 16'h0008);
    tick(8);
  endtask
  task do_return_from_irq_instr;
    @(posedge clk);
    return_from_irq_instr_cmd <= 1'b1;
    @(posedge clk);
    return_from_irq_instr_cmd <= 1'b0;
    tick(3);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_regs;
    for (int a = 0; a < 9; a++) rd(a[7:0], 8'h00);
    rd(8'h20, 8'h00);
  endtask
  task t_pend;
    ev(14'h0008);
    pin <= 14'h0010;
    tick(5);
    rd(8'h06, 8'h18);
    chk({15'h0000, req}, 16'h0000);
    wr(8'h06, 8'h00);
    pin <= 14'h0000;
  endtask
  task t_clear;
    multi_s <= 1'b1;
    wr(8'h00, 8'h88);
    @(posedge clk);
    addr <= 8'h00;
    wd <= 8'h08;
    wr_s <= 1'b1;
    ev_s <= 14'h0008;
    @(posedge clk);
    wr_s <= 1'b0;
    ev_s <= 14'h0000;
    tick(12);
    chk({14'h0000, ins}, 16'h0000);
    rd(8'h06, 8'h08);
    wr(8'h06, 8'h00);
    multi_s <= 1'b0;
  endtask
  task t_global;
    wr(8'h00, 8'h04);
    ev(14'h0004);
    tick(4);
    chk({15'h0000, req}, 16'h0000);
    wr(8'h00, 8'h84);
    wait_call(4'h2);
    chk({14'h0000, ins}, 16'h0001);
    wr(8'h06, 8'h00);
    do_return_from_irq_instr;
    chk({14'h0000, ins}, 16'h0000);
  endtask
  task t_reenter;
    wr(8'h00, 8'h81);
    wr(8'h06, 8'h01);
    wait_call(4'h0);
    do_return_from_irq_instr;
    wait_call(4'h0);
    wr(8'h06, 8'h00);
    do_return_from_irq_instr;
  endtask
  task t_soft;
    slow <= 1'b1;
    hw <= 14'h0200;
    wr(8'h02, 8'h04);
    wr(8'h07, 8'h02);
    wait_call(4'h9);
    rd(8'h07, 8'h00);
    do_return_from_irq_instr;
    slow <= 1'b0;
    hw <= 14'h0000;
    wr(8'h02, 8'h00);
  endtask
  task t_prio;
    wr(8'h03, 8'h20);
    wr(8'h00, 8'ha2);
    ev(14'h0022);
    wait_call(4'h5);
    tick(10);
    chk({14'h0000, ins, call}, 16'h0004);
    wr(8'h06, 8'h02);
    do_return_from_irq_instr;
    wait_call(4'h1);
    ev(14'h0020);
    wait_call(4'h5);
    chk({14'h0000, ins}, 16'h0003);
    wr(8'h06, 8'h00);
    do_return_from_irq_instr;
    chk({14'h0000, ins}, 16'h0001);
    do_return_from_irq_instr;
    wr(8'h03, 8'h00);
    ev(14'h0022);
    wait_call(4'h1);
    wr(8'h06, 8'h00);
    do_return_from_irq_instr;
  endtask
  // ****************************************************************
  // main sequence and hang guard
  // ****************************************************************
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      stop_test;
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_pend;
    t_clear;
    t_global;
    t_reenter;
    t_soft;
    t_prio;
    stop_test;
  end
endmodule // testbench
